// ==== hw/cfs_regs.svh ====
// register offsets, field positions and reset values of the fifo status block
// assumes it is included by bare name wherever these constants are needed
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH

// ----------------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------------
`define CFS_SEL_STATUS       1'b0
`define CFS_SEL_USER_ADDR    1'b1

// ----------------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------------
`define CFS_IDX_HI           12
`define CFS_IDX_LO           8
`define CFS_BIT_ABORT        7
`define CFS_BIT_LARB         6
`define CFS_BIT_BUSERR       5
`define CFS_BIT_ATTEMPTS     4
`define CFS_BIT_OVERFLOW     3
`define CFS_BIT_EMPTY_FULL   2
`define CFS_BIT_HALF         1
`define CFS_BIT_NOTFULL_NE   0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CFS_RST_WORD         32'h0000_0000
`define CFS_RST_PTR          5'h00
`define CFS_RST_COUNT        6'h00

`endif

// ==== hw/cfs_pkg.sv ====
// types shared by the fifo status block and its sub-modules
// assumes nothing of its surroundings
package cfs_pkg;

    // ------------------------------------------------------------------
    // transmit slot tracking
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CFS_TX_IDLE    = 3'b001,
        CFS_TX_PENDING = 3'b010,
        CFS_TX_ACTIVE  = 3'b100
    } cfs_tx_state_t;

    typedef logic [4:0]  cfs_ptr_t;
    typedef logic [5:0]  cfs_count_t;
    typedef logic [31:0] cfs_word_t;

endpackage

// ==== hw/cfs_occ_if.sv ====
// occupancy signals passed between the counter, the flag logic and the top
// assumes one clock shared by all users
`timescale 1ns/1ps
interface cfs_occ_if;
    import cfs_pkg::*;

    logic       push;
    logic       pop;
    logic       flush;
    cfs_count_t depth;
    cfs_count_t count;
    cfs_ptr_t   head;
    cfs_ptr_t   tail;
    logic       full;
    logic       empty;
    logic       dropped;

    modport ctr  (input push, pop, flush, depth, output count, head, tail, full, empty, dropped);
    modport flg  (input count, depth);
    modport user (output push, pop, flush, depth, input count, head, tail, full, empty, dropped);
endinterface

// ==== hw/cfs_occupancy.sv ====
// head, tail and occupancy counter of one message fifo
// assumes push and pop are single-cycle strobes on the core clock
`timescale 1ns/1ps
module cfs_occupancy
    import cfs_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    cfs_occ_if.ctr    occ
);
`include "cfs_regs.svh"

    function automatic cfs_ptr_t wrap_inc(input cfs_ptr_t p, input cfs_count_t d);
        wrap_inc = ({1'b0, p} + 6'h01 >= d) ? `CFS_RST_PTR : p + 5'h01;
    endfunction

    logic do_push;
    logic do_pop;

    // pushes into a full fifo are dropped unless a pop comes in the same cycle; never overwrite
    assign occ.full    = (occ.count >= occ.depth);
    assign occ.empty   = (occ.count == `CFS_RST_COUNT);
    assign do_push     = occ.push & (~occ.full | occ.pop);
    assign do_pop      = occ.pop & ~occ.empty;
    assign occ.dropped = occ.push & occ.full & ~occ.pop;

    always_ff @(posedge clk_i) begin
        if (!rstn_i || occ.flush) begin
            occ.head  <= `CFS_RST_PTR;
            occ.tail  <= `CFS_RST_PTR;
            occ.count <= `CFS_RST_COUNT;
        end else begin
            if (do_push) begin
                occ.head <= wrap_inc(occ.head, occ.depth);
            end
            if (do_pop) begin
                occ.tail <= wrap_inc(occ.tail, occ.depth);
            end
            if (do_push && !do_pop) begin
                occ.count <= occ.count + 6'h01;
            end else if (do_pop && !do_push) begin
                occ.count <= occ.count - 6'h01;
            end
        end
    end
endmodule

// ==== hw/cfs_level_flags.sv ====
// occupancy level comparisons for the three level flags
// assumes count never exceeds depth
`timescale 1ns/1ps
module cfs_level_flags
    import cfs_pkg::*;
(
    cfs_occ_if.flg    occ,
    output logic      at_or_below_half_o,
    output logic      at_or_above_half_o,
    output logic      is_full_o,
    output logic      is_empty_o
);
    logic [6:0] twice;
    logic [6:0] depth_w;

    // compare twice the count to avoid rounding odd depths
    assign twice              = {occ.count, 1'b0};
    assign depth_w            = {1'b0, occ.depth};
    assign at_or_below_half_o = (twice <= depth_w);
    assign at_or_above_half_o = (twice >= depth_w);
    assign is_full_o          = (occ.count >= occ.depth);
    assign is_empty_o         = (occ.count == 6'h00);
endmodule

// ==== hw/cfs_fifo_status.sv ====
// fifo status and user address registers of one message fifo
// assumes the spi block, the protocol engine and the ram live on the core clock
//
// What this block does
// - message index is zero-based: next to send on tx, next slot filled on rx
// - message index runs from zero to configured depth minus one
// - abort flag reads one when the last tx message was aborted during an active send; an abort while pending leaves it unchanged
// - lost-arbitration flag reads one when the message lost arbitration
// - bus-error flag reads one when a bus error hit the message
// - the three outcome flags clear on transmit request set or host zero write
// - outcome flags change only on message completion, abort, fifo reset, transmit request set or host zero write
// - attempts-exhausted flag pending on tx, reads zero on rx
// - overflow flag sets on rx overflow, reads zero on tx
// - tx: bit two reads one when empty, zero when anything queued
// - rx: bit two is the full flag, zero when not full
// - tx: half flag one when occupancy at or below half depth
// - rx: half flag one when occupancy at or above half depth
// - tx: lowest flag one while not full
// - rx: lowest flag one while at least one message held
// - tx: user address reads ram address of the head
// - rx: user address reads ram address of the tail
`timescale 1ns/1ps
module cfs_fifo_status
    import cfs_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RSTN_I,
    // fifo configuration
    input  wire logic        DIRECTION_IS_TRANSMIT_I,
    input  wire logic [4:0]  DEPTH_CODE_I,
    input  wire logic [31:0] FIFO_BASE_ADDR_I,
    input  wire logic [11:0] OBJECT_BYTES_I,
    input  wire logic        CONFIG_MODE_I,
    input  wire logic        FIFO_RESET_I,
    // host side events
    input  wire logic        TRANSMIT_REQUEST_SET_I,
    input  wire logic        HOST_INCREMENT_I,
    // protocol engine events
    input  wire logic        TX_START_I,
    input  wire logic        TX_DONE_I,
    input  wire logic        TX_ABORTED_I,
    input  wire logic        TX_LOST_ARB_I,
    input  wire logic        TX_BUS_ERROR_I,
    input  wire logic        TX_ATTEMPTS_EXHAUSTED_I,
    input  wire logic        RX_STORE_I,
    input  wire logic        RX_OVERFLOW_I,
    // register access
    input  wire logic        REG_SEL_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [3:0]  REG_BE_I,
    input  wire logic [31:0] REG_WDATA_I,
    output logic      [31:0] REG_RDATA_O,
    output logic             REG_RVALID_O,
    // status toward the engine
    output logic             FIFO_FULL_O,
    output logic             FIFO_EMPTY_O,
    output logic             TX_BUSY_O
);
`include "cfs_regs.svh"

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // ram address of a message slot; used for head and tail
    function automatic cfs_word_t slot_addr(input cfs_word_t base,
                                            input cfs_ptr_t  idx,
                                            input logic [11:0] obj);
        logic [16:0] off;
        off       = 17'(idx) * 17'(obj);
        slot_addr = base + {15'h0000, off};
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    cfs_occ_if        occ ();

    cfs_tx_state_t    tx_state_q;
    cfs_tx_state_t    tx_state_d;

    logic             is_tx;
    logic             below_half;
    logic             above_half;
    logic             lvl_full;
    logic             lvl_empty;

    logic             aborted_q;
    logic             lost_arb_q;
    logic             bus_err_q;
    logic             attempts_q;
    logic             overflow_q;

    logic             host_wr_status;
    logic             clr_abort;
    logic             clr_larb;
    logic             clr_buserr;
    logic             clr_attempts;
    logic             clr_overflow;
    logic             outcome_event;
    logic             outcome_clear;
    logic             overflow_event;
    logic             tx_pop;

    cfs_ptr_t         msg_index;
    logic             flag_bit2;
    logic             flag_bit1;
    logic             flag_bit0;
    cfs_word_t        status_word;
    cfs_word_t        user_addr_word;
    cfs_word_t        user_addr_q;

    // ------------------------------------------------------------------
    // occupancy counter and level comparisons
    // ------------------------------------------------------------------
    assign is_tx = DIRECTION_IS_TRANSMIT_I;

    // depth code n means n+1 messages
    assign occ.depth = {1'b0, DEPTH_CODE_I} + 6'h01;
    assign occ.flush = FIFO_RESET_I;

    // tx: host queues, successful send drains; rx: engine stores, host drains
    assign tx_pop   = (tx_state_q == CFS_TX_ACTIVE) & TX_DONE_I;
    assign occ.push = is_tx ? HOST_INCREMENT_I : RX_STORE_I;
    assign occ.pop  = is_tx ? tx_pop : HOST_INCREMENT_I;

    cfs_occupancy u_occupancy (
        .clk_i  (CORE_CLK_I),
        .rstn_i (RSTN_I),
        .occ    (occ.ctr)
    );

    cfs_level_flags u_level_flags (
        .occ                (occ.flg),
        .at_or_below_half_o (below_half),
        .at_or_above_half_o (above_half),
        .is_full_o          (lvl_full),
        .is_empty_o         (lvl_empty)
    );

    // ------------------------------------------------------------------
    // transmit slot tracking
    // ------------------------------------------------------------------
    // completion strobes outside an active send are ignored, so a stray
    // strobe cannot disturb the outcome flags
    always_comb begin
        tx_state_d = tx_state_q;
        case (tx_state_q)
            CFS_TX_IDLE: begin
                if (TRANSMIT_REQUEST_SET_I && is_tx) begin
                    tx_state_d = CFS_TX_PENDING;
                end
            end
            CFS_TX_PENDING: begin
                if (TX_ABORTED_I) begin
                    tx_state_d = CFS_TX_IDLE;
                end else if (TX_START_I) begin
                    tx_state_d = CFS_TX_ACTIVE;
                end
            end
            CFS_TX_ACTIVE: begin
                if (TX_DONE_I || TX_ABORTED_I) begin
                    tx_state_d = (occ.count > 6'h01 || TX_ABORTED_I) ?
                                 CFS_TX_PENDING : CFS_TX_IDLE;
                    if (TX_ABORTED_I) begin
                        tx_state_d = CFS_TX_IDLE;
                    end
                end
            end
            default: begin
                tx_state_d = CFS_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I || FIFO_RESET_I || !is_tx) begin
            tx_state_q <= CFS_TX_IDLE;
        end else begin
            tx_state_q <= tx_state_d;
        end
    end

    // ------------------------------------------------------------------
    // host clear strobes
    // ------------------------------------------------------------------
    // writing one to a flag has no effect; only a zero clears it
    assign host_wr_status = REG_WR_I & (REG_SEL_I == `CFS_SEL_STATUS) & REG_BE_I[0];
    assign clr_abort      = host_wr_status & ~REG_WDATA_I[`CFS_BIT_ABORT];
    assign clr_larb       = host_wr_status & ~REG_WDATA_I[`CFS_BIT_LARB];
    assign clr_buserr     = host_wr_status & ~REG_WDATA_I[`CFS_BIT_BUSERR];
    assign clr_attempts   = host_wr_status & ~REG_WDATA_I[`CFS_BIT_ATTEMPTS];
    assign clr_overflow   = host_wr_status & ~REG_WDATA_I[`CFS_BIT_OVERFLOW];

    // ------------------------------------------------------------------
    // transmit outcome flags
    // ------------------------------------------------------------------
    assign outcome_event = (tx_state_q == CFS_TX_ACTIVE) & (TX_DONE_I | TX_ABORTED_I);
    assign outcome_clear = TRANSMIT_REQUEST_SET_I;

    // an outcome in the same cycle as a clear wins over the clear
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I || FIFO_RESET_I) begin
            aborted_q <= 1'b0;
        end else if (outcome_event) begin
            aborted_q <= TX_ABORTED_I & ~TX_DONE_I;
        end else if (outcome_clear || clr_abort) begin
            aborted_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I || FIFO_RESET_I) begin
            lost_arb_q <= 1'b0;
        end else if (outcome_event) begin
            lost_arb_q <= TX_LOST_ARB_I;
        end else if (outcome_clear || clr_larb) begin
            lost_arb_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I || FIFO_RESET_I) begin
            bus_err_q <= 1'b0;
        end else if (outcome_event) begin
            bus_err_q <= TX_BUS_ERROR_I;
        end else if (outcome_clear || clr_buserr) begin
            bus_err_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // sticky interrupt flags
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I || FIFO_RESET_I || !is_tx) begin
            attempts_q <= 1'b0;
        end else if (TX_ATTEMPTS_EXHAUSTED_I) begin
            attempts_q <= 1'b1;
        end else if (clr_attempts) begin
            attempts_q <= 1'b0;
        end
    end

    // overflow from the engine or a store dropped on a full fifo
    assign overflow_event = ~is_tx & (RX_OVERFLOW_I | occ.dropped);

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I || FIFO_RESET_I || is_tx) begin
            overflow_q <= 1'b0;
        end else if (overflow_event) begin
            overflow_q <= 1'b1;
        end else if (clr_overflow) begin
            overflow_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // level flags and message index
    // ------------------------------------------------------------------
    // tx index follows the tail (next to send), rx the head (next slot)
    assign msg_index = is_tx ? occ.tail : occ.head;

    // rx bit two is driven as full; the printed "1 = empty" is taken as a typo
    assign flag_bit2 = is_tx ? lvl_empty : lvl_full;
    assign flag_bit1 = is_tx ? below_half : above_half;
    assign flag_bit0 = is_tx ? ~lvl_full : ~lvl_empty;

    always_comb begin
        status_word                                = `CFS_RST_WORD;
        status_word[`CFS_IDX_HI:`CFS_IDX_LO]       = msg_index;
        status_word[`CFS_BIT_ABORT]                = aborted_q;
        status_word[`CFS_BIT_LARB]                 = lost_arb_q;
        status_word[`CFS_BIT_BUSERR]               = bus_err_q;
        status_word[`CFS_BIT_ATTEMPTS]             = attempts_q;
        status_word[`CFS_BIT_OVERFLOW]             = overflow_q;
        status_word[`CFS_BIT_EMPTY_FULL]           = flag_bit2;
        status_word[`CFS_BIT_HALF]                 = flag_bit1;
        status_word[`CFS_BIT_NOTFULL_NE]           = flag_bit0;
    end

    // ------------------------------------------------------------------
    // user address
    // ------------------------------------------------------------------
    // ram layout may be rewritten in configuration mode, so the value then
    // is only the last one computed; the host must not rely on it
    assign user_addr_word = is_tx ?
                            slot_addr(FIFO_BASE_ADDR_I, occ.head, OBJECT_BYTES_I) :
                            slot_addr(FIFO_BASE_ADDR_I, occ.tail, OBJECT_BYTES_I);

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            user_addr_q <= `CFS_RST_WORD;
        end else if (!CONFIG_MODE_I) begin
            user_addr_q <= user_addr_word;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            REG_RDATA_O <= `CFS_RST_WORD;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= (REG_SEL_I == `CFS_SEL_USER_ADDR) ? user_addr_q : status_word;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
        end
    end

    // ------------------------------------------------------------------
    // engine status
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            FIFO_FULL_O  <= 1'b0;
            FIFO_EMPTY_O <= 1'b1;
            TX_BUSY_O    <= 1'b0;
        end else begin
            FIFO_FULL_O  <= lvl_full;
            FIFO_EMPTY_O <= lvl_empty;
            TX_BUSY_O    <= (tx_state_d != CFS_TX_IDLE);
        end
    end
endmodule

// ==== verification/cfs_host_model.sv ====
// host side model: register reads and writes toward the fifo status block
// assumes each call starts in the time step of a core clock edge
`timescale 1ns/1ps
module cfs_host_model (
    // clock and mode
    input  wire logic        clk_i,
    input  wire logic        cfg_i,
    // register access
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic             sel_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [3:0]  be_o,
    output logic      [31:0] wdata_o
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    initial begin
        sel_o   = 1'b0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        be_o    = 4'h0;
        wdata_o = 32'h0;
    end

    task automatic wr(input logic s, input logic [31:0] d);
        sel_o   <= s;
        be_o    <= 4'h1;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        be_o    <= 4'h0;
        // idle data bus never repeats the last word
        wdata_o <= ~d;
    endtask

    task automatic rd(input logic s, output logic [31:0] d, output logic v);
        if (s) wait (!cfg_i);
        sel_o <= s;
        rd_o  <= 1'b1;
        @(posedge clk_i);
        rd_o  <= 1'b0;
        // sample at the falling edge, where the answer has settled
        @(negedge clk_i);
        v = rvalid_i;
        d = rdata_i;
        @(posedge clk_i);
    endtask
endmodule

// ==== verification/cfs_fifo_status_props.sv ====
// assertions on the top ports of the fifo status block
// assumes one core clock; bound to the top at the foot of this file
`timescale 1ns/1ps
module cfs_fifo_status_props (
    // clock, reset and events
    input wire logic        CORE_CLK_I,
    input wire logic        RSTN_I,
    input wire logic        DIRECTION_IS_TRANSMIT_I,
    input wire logic        FIFO_RESET_I,
    input wire logic        TRANSMIT_REQUEST_SET_I,
    input wire logic        HOST_INCREMENT_I,
    input wire logic        TX_DONE_I,
    input wire logic        TX_ABORTED_I,
    input wire logic        RX_STORE_I,
    // register access and status
    input wire logic        REG_SEL_I,
    input wire logic        REG_WR_I,
    input wire logic        REG_RD_I,
    input wire logic [3:0]  REG_BE_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic        REG_RVALID_O,
    input wire logic        FIFO_FULL_O,
    input wire logic        FIFO_EMPTY_O
);
    // ----------------------------------------------------------------
    // helpers and sequences
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    wire tx  = DIRECTION_IS_TRANSMIT_I;
    wire mv  = HOST_INCREMENT_I | TX_DONE_I | RX_STORE_I | FIFO_RESET_I;
    wire ev  = TX_DONE_I | TX_ABORTED_I;
    wire chg = ev | FIFO_RESET_I | REG_WR_I | TRANSMIT_REQUEST_SET_I;
    sequence s_rd; REG_RD_I && !REG_SEL_I; endsequence
    // level copies lag a cycle, so only compare when occupancy sat still
    sequence s_qrd; s_rd ##0 (!mv && !$past(mv) && $stable(tx)); endsequence
    sequence s_clr; REG_WR_I && !REG_SEL_I && REG_BE_I[0] && REG_WDATA_I[7:5] == 3'h0 && !ev; endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_att_rx; s_rd ##0 !tx |=> !REG_RDATA_O[4]; endproperty
    a_att_rx: assert property (p_att_rx) else $error("attempts bit set in rx");
    property p_ovf_tx; s_rd ##0 tx |=> !REG_RDATA_O[3]; endproperty
    a_ovf_tx: assert property (p_ovf_tx) else $error("overflow bit set in tx");
    property p_tx_empty; s_qrd ##0 tx |=> REG_RDATA_O[2] == FIFO_EMPTY_O; endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("tx empty bit wrong");
    property p_rx_full; s_qrd ##0 !tx |=> REG_RDATA_O[2] == FIFO_FULL_O; endproperty
    a_rx_full: assert property (p_rx_full) else $error("rx full bit wrong");
    property p_tx_nf; s_qrd ##0 tx |=> REG_RDATA_O[0] == !FIFO_FULL_O; endproperty
    a_tx_nf: assert property (p_tx_nf) else $error("tx not full bit wrong");
    property p_rx_ne; s_qrd ##0 !tx |=> REG_RDATA_O[0] == !FIFO_EMPTY_O; endproperty
    a_rx_ne: assert property (p_rx_ne) else $error("rx not empty bit wrong");
    property p_clr; s_clr ##1 (s_rd ##0 !ev) |=> REG_RDATA_O[7:5] == 3'h0; endproperty
    a_clr: assert property (p_clr) else $error("outcome bits not cleared");
    property p_hold;
        s_rd ##0 !chg ##1 !chg ##1 s_rd ##0 $stable(tx) |=> REG_RDATA_O[7:5] == $past(REG_RDATA_O[7:5], 2);
    endproperty
    a_hold: assert property (p_hold) else $error("outcome bits moved");
    property p_excl; !(FIFO_FULL_O && FIFO_EMPTY_O); endproperty
    a_excl: assert property (p_excl) else $error("full and empty together");
endmodule

bind cfs_fifo_status cfs_fifo_status_props u_props (.*);

// ==== verification/cfs_fifo_status_test.sv ====
// self-checking bench for the fifo status block
// assumes the host model and the checker are compiled before it
`timescale 1ns/1ps
module cfs_fifo_status_test
    import cfs_pkg::*;
;
    // ----------------------------------------------------------------
    // signals, design and host
    // ----------------------------------------------------------------
    localparam cfs_word_t BASE = 32'h0000_0400;
    localparam cfs_word_t OBJ  = 32'h0000_0048;
    logic        clk          = 1'b0;
    logic        rstn         = 1'b0;
    logic        dir          = 1'b1;
    logic        cfg          = 1'b0;
    logic        larb         = 1'b0;
    logic        berr         = 1'b0;
    logic [8:0]  ev           = 9'h000;
    logic        sel;
    logic        wr;
    logic        rd;
    logic [3:0]  be;
    cfs_word_t   wdata;
    cfs_word_t   rdata;
    logic        rvalid;
    logic        busy;
    int          failures     = 0;
    int          total_checks = 0;
    int          cyc          = 0;

    always #2.5 clk = ~clk;

    cfs_fifo_status u_dut (
        .CORE_CLK_I(clk), .RSTN_I(rstn), .DIRECTION_IS_TRANSMIT_I(dir),
        .DEPTH_CODE_I(5'h03), .FIFO_BASE_ADDR_I(BASE), .OBJECT_BYTES_I(OBJ[11:0]),
        .CONFIG_MODE_I(cfg), .FIFO_RESET_I(ev[8]), .TRANSMIT_REQUEST_SET_I(ev[0]),
        .HOST_INCREMENT_I(ev[1]), .TX_START_I(ev[2]), .TX_DONE_I(ev[3]),
        .TX_ABORTED_I(ev[4]), .TX_LOST_ARB_I(larb), .TX_BUS_ERROR_I(berr),
        .TX_ATTEMPTS_EXHAUSTED_I(ev[5]), .RX_STORE_I(ev[6]), .RX_OVERFLOW_I(ev[7]),
        .REG_SEL_I(sel), .REG_WR_I(wr), .REG_RD_I(rd), .REG_BE_I(be),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .FIFO_FULL_O(), .FIFO_EMPTY_O(), .TX_BUSY_O(busy)
    );

    cfs_host_model u_host (
        .clk_i(clk), .cfg_i(cfg), .rdata_i(rdata), .rvalid_i(rvalid),
        .sel_o(sel), .wr_o(wr), .rd_o(rd), .be_o(be), .wdata_o(wdata)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input cfs_word_t seen, input cfs_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // extra edge at the end keeps two pulses from sharing a time step
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(posedge clk);
    endtask

    task automatic txp(input int i, input logic la, input logic er);
        larb <= la;
        berr <= er;
        pulse(i);
        larb <= 1'b0;
        berr <= 1'b0;
    endtask

    // read twice so the outcome bits are seen to hold between reads
    task automatic stat(input cfs_word_t exp);
        cfs_word_t d;
        logic      v;
        repeat (2) begin
            u_host.rd(1'b0, d, v);
            chk(v ? d : ~exp, exp);
        end
    endtask

    task automatic ua(input cfs_word_t exp);
        cfs_word_t d;
        logic      v;
        u_host.rd(1'b1, d, v);
        chk(v ? d : ~exp, exp);
    endtask

    task automatic final_report();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        stat(32'h0000_0007);
        repeat (3) pulse(1);
        stat(32'h0000_0001);
        ua(BASE + 3 * OBJ);
        repeat (2) pulse(1);
        stat(32'h0000_0000);
        pulse(0);
        pulse(2);
        txp(3, 1'b1, 1'b0);
        stat(32'h0000_0141);
        chk({31'h0, busy}, 32'h1);
        pulse(2);
        txp(4, 1'b0, 1'b1);
        stat(32'h0000_01a1);
        chk({31'h0, busy}, 32'h0);
        u_host.wr(1'b0, 32'h0000_00e0);
        stat(32'h0000_01a1);
        u_host.wr(1'b0, 32'h0000_0000);
        stat(32'h0000_0101);
        pulse(0);
        pulse(2);
        txp(3, 1'b0, 1'b1);
        stat(32'h0000_0223);
        pulse(0);
        stat(32'h0000_0203);
        pulse(5);
        stat(32'h0000_0213);
        pulse(3);
        stat(32'h0000_0213);
        // receive direction from a clean fifo
        dir <= 1'b0;
        pulse(8);
        stat(32'h0000_0000);
        repeat (2) pulse(6);
        stat(32'h0000_0203);
        ua(BASE);
        pulse(1);
        stat(32'h0000_0201);
        ua(BASE + OBJ);
        repeat (3) pulse(6);
        stat(32'h0000_0107);
        pulse(6);
        stat(32'h0000_010f);
        pulse(8);
        pulse(7);
        stat(32'h0000_0008);
        final_report();
    end
endmodule
